//--- domc_cnt.sv
`timescale 1ns/1ns
// Saturating timeout counter: restarts on clear, flags when it reaches the limit
module domc_cnt #(
	parameter int W = 24
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Control
	input wire logic i_run,
	input wire logic [W-1:0] i_limit,
	// Result
	output logic o_expired
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic exp_r;
	logic exp_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		exp_nxt = 1'b0;
		if (!i_run) begin
			cnt_nxt = '0;
		end else if (cnt_r >= i_limit) begin
			exp_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
			exp_r <= 1'b0;
		end else if (i_ce) begin
			cnt_r <= cnt_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign o_expired = exp_r;
endmodule : domc_cnt

//--- domc_ctrl.sv
`timescale 1ns/1ns
module domc_ctrl #(
	parameter int CH = domc_pkg::CHANNELS,
	parameter int STDBY_CYC = domc_pkg::STDBY_OUT_CYC,
	parameter int WDT_CYC = domc_pkg::WATCHDOG_TOGGLE_BIT_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Supplies and sensing
	input wire logic i_vdd_por_ok,
	input wire logic i_vcc_uv,
	input wire logic i_case_hot,
	input wire logic i_case_cool,
	// Pins and SPI-written bits
	input wire logic [CH-1:0] i_direct_channel_inputs,
	input wire logic i_chip_select_low,
	input wire logic i_spi_wr,
	input wire domc_pkg::domc_ctrl_t i_ctrl,
	input wire logic [CH-1:0] i_spi_out_ctrl,
	// Results
	output domc_pkg::domc_mode_t o_mode,
	output domc_pkg::domc_stat_t o_stat,
	output logic [CH-1:0] o_out_on,
	output logic o_case_warn
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rs1_r;
	logic rs2_r;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end
	wire rst_n = rs2_r;

	// ****************************************
	// Mode machine
	// ****************************************
	domc_pkg::domc_mode_t mode_r;
	domc_pkg::domc_mode_t mode_nxt;
	logic [CH-1:0] in_q_r;
	logic unlock_r;
	logic unlock_nxt;
	logic wd_q_r;
	logic por_flag_r;
	logic por_flag_nxt;
	logic sw_flag_r;
	logic sw_flag_nxt;
	logic cs_exp;
	logic wd_exp;
	logic wd_run;

	wire any_rise = |(i_direct_channel_inputs & ~in_q_r);
	wire all_low = ~|i_direct_channel_inputs;
	wire cs_run = i_chip_select_low &&
		(mode_r == domc_pkg::MODE_STANDBY || mode_r == domc_pkg::MODE_SLEEP2);
	wire wd_toggle = i_ctrl.watchdog_toggle_bit != wd_q_r;
	assign wd_run = (mode_r == domc_pkg::MODE_NORMAL) && !wd_toggle;

	domc_cnt #(.W(domc_pkg::CNT_W)) u_cs_cnt (
		.i_mclk(i_mclk), .i_rst_n(rst_n), .i_ce(i_ce), .i_run(cs_run),
		.i_limit(domc_pkg::CNT_W'(STDBY_CYC)), .o_expired(cs_exp));
	domc_cnt #(.W(domc_pkg::CNT_W)) u_wd_cnt (
		.i_mclk(i_mclk), .i_rst_n(rst_n), .i_ce(i_ce), .i_run(wd_run),
		.i_limit(domc_pkg::CNT_W'(WDT_CYC)), .o_expired(wd_exp));

	always_comb begin
		mode_nxt = mode_r;
		unlock_nxt = unlock_r;
		por_flag_nxt = por_flag_r;
		sw_flag_nxt = sw_flag_r;
		case (mode_r)
			domc_pkg::MODE_RESET: begin
				unlock_nxt = 1'b0;
				if (i_vdd_por_ok) begin
					mode_nxt = domc_pkg::MODE_FAIL_SAFE;
					por_flag_nxt = 1'b1;
				end else if (all_low) begin
					mode_nxt = domc_pkg::MODE_SLEEP1;
				end
			end
			domc_pkg::MODE_SLEEP1: begin
				unlock_nxt = 1'b0;
				if (i_vdd_por_ok) begin
					mode_nxt = domc_pkg::MODE_FAIL_SAFE;
					por_flag_nxt = 1'b1;
				end else if (any_rise) begin
					mode_nxt = domc_pkg::MODE_RESET;
				end
			end
			domc_pkg::MODE_FAIL_SAFE, domc_pkg::MODE_NORMAL: begin
				if (!i_vdd_por_ok) begin
					mode_nxt = domc_pkg::MODE_RESET;
				end else if (mode_r == domc_pkg::MODE_NORMAL &&
					(i_ctrl.soft_reset || wd_exp || (i_spi_wr && !i_ctrl.run_enable &&
					!(unlock_r && i_ctrl.standby_request)))) begin
					mode_nxt = domc_pkg::MODE_FAIL_SAFE;
					sw_flag_nxt = i_ctrl.soft_reset;
					por_flag_nxt = 1'b0;
					unlock_nxt = 1'b0;
				end else if (i_spi_wr) begin
					if (i_ctrl.unlock) begin
						unlock_nxt = 1'b1;
					end else if (unlock_r && !i_ctrl.standby_request && i_ctrl.run_enable) begin
						if (mode_r == domc_pkg::MODE_FAIL_SAFE) begin
							mode_nxt = domc_pkg::MODE_NORMAL;
						end
						unlock_nxt = 1'b0;
					end else if (unlock_r && i_ctrl.standby_request && !i_ctrl.run_enable) begin
						mode_nxt = domc_pkg::MODE_STANDBY;
						unlock_nxt = 1'b0;
					end else begin
						unlock_nxt = 1'b0;
					end
					if (mode_r == domc_pkg::MODE_FAIL_SAFE && i_ctrl.soft_reset) begin
						sw_flag_nxt = 1'b1;
					end
				end
				if (mode_nxt != domc_pkg::MODE_FAIL_SAFE && mode_nxt != mode_r) begin
					por_flag_nxt = 1'b0;
					sw_flag_nxt = 1'b0;
				end
			end
			domc_pkg::MODE_STANDBY, domc_pkg::MODE_SLEEP2: begin
				unlock_nxt = 1'b0;
				if (!i_vdd_por_ok) begin
					mode_nxt = domc_pkg::MODE_RESET;
				end else if (cs_exp) begin
					mode_nxt = domc_pkg::MODE_FAIL_SAFE;
				end else if (mode_r == domc_pkg::MODE_STANDBY && all_low) begin
					mode_nxt = domc_pkg::MODE_SLEEP2;
				end else if (mode_r == domc_pkg::MODE_SLEEP2 && any_rise) begin
					mode_nxt = domc_pkg::MODE_STANDBY;
				end
			end
			default: begin
				mode_nxt = domc_pkg::MODE_RESET;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= domc_pkg::MODE_RESET;
			in_q_r <= '0;
			unlock_r <= 1'b0;
			wd_q_r <= 1'b0;
			por_flag_r <= 1'b0;
			sw_flag_r <= 1'b0;
		end else if (i_ce) begin
			mode_r <= mode_nxt;
			in_q_r <= i_direct_channel_inputs;
			unlock_r <= unlock_nxt;
			wd_q_r <= i_ctrl.watchdog_toggle_bit;
			por_flag_r <= por_flag_nxt;
			sw_flag_r <= sw_flag_nxt;
		end
	end

	// ****************************************
	// Outputs and status
	// ****************************************
	domc_pkg::domc_stat_t stat_r;
	domc_pkg::domc_stat_t stat_nxt;
	logic [CH-1:0] out_r;
	logic [CH-1:0] out_nxt;
	logic warn_r;
	logic warn_nxt;

	always_comb begin
		stat_nxt = '0;
		out_nxt = '0;
		warn_nxt = warn_r;
		if (i_case_hot) begin
			warn_nxt = 1'b1;
		end else if (i_case_cool) begin
			warn_nxt = 1'b0;
		end
		case (mode_r)
			domc_pkg::MODE_RESET: begin
				out_nxt = i_direct_channel_inputs;
				stat_nxt.regs_clear = 1'b1;
			end
			domc_pkg::MODE_SLEEP1: begin
				stat_nxt.regs_clear = 1'b1;
			end
			domc_pkg::MODE_FAIL_SAFE: begin
				out_nxt = i_direct_channel_inputs;
				stat_nxt.spi_active = 1'b1;
				stat_nxt.regs_writable = 1'b1;
				stat_nxt.regs_clear = sw_flag_r;
				stat_nxt.spi_diag = 1'b1;
				stat_nxt.reset_bit = sw_flag_r | por_flag_r;
			end
			domc_pkg::MODE_NORMAL: begin
				out_nxt = i_spi_out_ctrl | i_direct_channel_inputs;
				stat_nxt.spi_active = 1'b1;
				stat_nxt.regs_writable = 1'b1;
				stat_nxt.spi_diag = 1'b1;
				stat_nxt.sense_diag = 1'b1;
			end
			domc_pkg::MODE_STANDBY, domc_pkg::MODE_SLEEP2: begin
				stat_nxt.cs_forced_high = 1'b1;
			end
			default: begin
				stat_nxt = '0;
			end
		endcase
		if (i_vcc_uv) begin
			out_nxt = '0;
			stat_nxt.sense_diag = 1'b0;
			stat_nxt.reset_bit = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= '0;
			out_r <= '0;
			warn_r <= 1'b0;
		end else if (i_ce) begin
			stat_r <= stat_nxt;
			out_r <= out_nxt;
			warn_r <= warn_nxt;
		end
	end

	assign o_mode = mode_r;
	assign o_stat = stat_r;
	assign o_out_on = out_r;
	assign o_case_warn = warn_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_unlock_then_run;
		i_ce && i_spi_wr && !i_ctrl.unlock && unlock_r && !i_ctrl.standby_request
			&& i_ctrl.run_enable && !i_vcc_uv;
	endsequence

	a_sleep1_rise: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && mode_r == domc_pkg::MODE_SLEEP1 && !i_vdd_por_ok && any_rise)
			|=> mode_r == domc_pkg::MODE_RESET) else $error("sleep1 wake missed");
	a_fs_to_normal: assert property (@(posedge i_mclk) disable iff (!rst_n)
		((mode_r == domc_pkg::MODE_FAIL_SAFE && i_vdd_por_ok) and s_unlock_then_run)
			|=> mode_r == domc_pkg::MODE_NORMAL) else $error("normal entry missed");
	a_normal_entry: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(mode_r == domc_pkg::MODE_NORMAL && $past(mode_r) == domc_pkg::MODE_FAIL_SAFE)
			|-> $past(unlock_r)) else $error("normal without unlock");
	a_standby_out: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && mode_r == domc_pkg::MODE_STANDBY) |=> (o_out_on == '0 &&
			!o_stat.spi_active && o_stat.cs_forced_high)) else $error("standby leak");
	a_uv_off: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && i_vcc_uv) |=> o_out_on == '0) else $error("undervoltage output on");
	a_wd_timeout: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && mode_r == domc_pkg::MODE_NORMAL && i_vdd_por_ok && wd_exp)
			|=> mode_r == domc_pkg::MODE_FAIL_SAFE) else $error("watchdog ignored");
	a_standby_sleep2: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && mode_r == domc_pkg::MODE_STANDBY && i_vdd_por_ok && !cs_exp && all_low)
			|=> mode_r == domc_pkg::MODE_SLEEP2) else $error("sleep2 entry missed");
	a_case_warn: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && i_case_hot) |=> o_case_warn) else $error("case warning not set");
	a_vdd_loss: assert property (@(posedge i_mclk) disable iff (!rst_n)
		(i_ce && !i_vdd_por_ok && mode_r != domc_pkg::MODE_RESET &&
			mode_r != domc_pkg::MODE_SLEEP1) |=> mode_r == domc_pkg::MODE_RESET)
		else $error("supply loss ignored");
endmodule : domc_ctrl

//--- domc_mcu.sv
`timescale 1ns/1ns
// ****************************************
// Controller model: control writes, watchdog toggling, chip select
// ****************************************
module domc_mcu (
	// Clock
	input wire logic i_mclk,
	// Toward the mode controller
	output logic o_spi_wr,
	output domc_pkg::domc_ctrl_t o_ctrl,
	output logic o_chip_select_low
);
	logic wr_r = 1'b0;
	logic cs_r = 1'b0;
	logic [3:0] cmd_r = 4'h0;
	logic dog_r = 1'b0;
	logic dog_on = 1'b0;
	logic [1:0] dog_cnt = 2'h0;
	assign o_spi_wr = wr_r;
	assign o_chip_select_low = cs_r;
	assign o_ctrl = {cmd_r, dog_r};
	// Inverts the toggle bit every fourth cycle while enabled
	always begin
		@(posedge i_mclk);
		#5;
		if (dog_on) begin
			dog_cnt = dog_cnt + 2'h1;
			if (dog_cnt == 2'h0) begin
				dog_r = ~dog_r;
			end
		end
	end
	// One write cycle of {unlock, standby, run enable, soft reset}; idle leaves all 0
	task automatic write(input logic [3:0] cmd);
		@(posedge i_mclk);
		#5;
		wr_r = 1'b1;
		cmd_r = cmd;
		@(posedge i_mclk);
		#5;
		wr_r = 1'b0;
		cmd_r = 4'h0;
	endtask : write
	task automatic cs_hold(input int n);
		@(posedge i_mclk);
		#5;
		cs_r = 1'b1;
		repeat (n) @(posedge i_mclk);
		#5;
		cs_r = 1'b0;
	endtask : cs_hold
endmodule : domc_mcu

//--- domc_pkg.sv
package domc_pkg;

	// ****************************************
	// Operating modes
	// ****************************************
	typedef enum logic [2:0] {
		MODE_RESET     = 3'h0,
		MODE_SLEEP1    = 3'h1,
		MODE_FAIL_SAFE = 3'h2,
		MODE_NORMAL    = 3'h3,
		MODE_STANDBY   = 3'h4,
		MODE_SLEEP2    = 3'h5
	} domc_mode_t;

	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int CHANNELS = 4;
	localparam int CLK_PERIOD_NS = 50;
	localparam int STDBY_OUT_NS = 50000;
	localparam int STDBY_OUT_CYC = (STDBY_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WATCHDOG_TOGGLE_BIT_TIMEOUT_US = 30000;
	localparam int WATCHDOG_TOGGLE_BIT_TIMEOUT_CYC = (WATCHDOG_TOGGLE_BIT_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

	// ****************************************
	// Grouped signals
	// ****************************************
	typedef struct packed {
		logic unlock;
		logic standby_request;
		logic run_enable;
		logic soft_reset;
		logic watchdog_toggle_bit;
	} domc_ctrl_t;

	typedef struct packed {
		logic spi_active;
		logic regs_writable;
		logic regs_clear;
		logic spi_diag;
		logic sense_diag;
		logic reset_bit;
		logic cs_forced_high;
	} domc_stat_t;

endpackage : domc_pkg

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic ce = 1'b1;
	logic vdd_ok = 1'b0;
	logic vcc_uv = 1'b0;
	logic hot = 1'b0;
	logic cool = 1'b0;
	logic [3:0] din = 4'h0;
	logic [3:0] spi_out = 4'h0;
	logic cs_low;
	logic spi_wr;
	domc_pkg::domc_ctrl_t ctrl;
	domc_pkg::domc_mode_t mode;
	domc_pkg::domc_stat_t stat;
	logic [3:0] out_on;
	logic warn;
	int miscompares = 0;
	int checked = 0;
	always #25 i_mclk = ~i_mclk;
	domc_ctrl #(.STDBY_CYC(8), .WDT_CYC(16)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_ce(ce), .i_vdd_por_ok(vdd_ok), .i_vcc_uv(vcc_uv), .i_case_hot(hot),
		.i_case_cool(cool), .i_direct_channel_inputs(din), .i_chip_select_low(cs_low),
		.i_spi_wr(spi_wr), .i_ctrl(ctrl), .i_spi_out_ctrl(spi_out), .o_mode(mode),
		.o_stat(stat), .o_out_on(out_on), .o_case_warn(warn));
	domc_mcu mcu (.i_mclk(i_mclk), .o_spi_wr(spi_wr), .o_ctrl(ctrl),
		.o_chip_select_low(cs_low));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#5;
	endtask : tick
	task automatic wm(input domc_pkg::domc_mode_t m);
		int k;
		k = 0;
		while (mode !== m && k < 40) begin
			tick(1);
			k++;
		end
		chk({5'h00, mode}, {5'h00, m});
		tick(2);
	endtask : wm
	function automatic logic [7:0] st4();
		return {3'h0, stat.regs_clear, stat.spi_active, stat.spi_diag, stat.sense_diag,
			stat.reset_bit};
	endfunction : st4
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_limp();
		wm(domc_pkg::MODE_SLEEP1);
		chk({out_on, stat.spi_active, stat.regs_clear, stat.spi_diag, stat.sense_diag}, 8'h04);
		din = 4'h2;
		wm(domc_pkg::MODE_RESET);
		vdd_ok = 1'b1;
		wm(domc_pkg::MODE_FAIL_SAFE);
		chk(st4() & 8'h0f, 8'h0d);
		din = 4'h9;
		tick(3);
		chk({4'h0, out_on}, 8'h09);
		$display("test limp done");
	endtask : t_limp
	task automatic t_normal();
		mcu.write(4'h2);
		tick(4);
		chk({5'h00, mode}, {5'h00, domc_pkg::MODE_FAIL_SAFE});
		mcu.dog_on = 1'b1;
		mcu.write(4'h8);
		mcu.write(4'h2);
		wm(domc_pkg::MODE_NORMAL);
		chk(st4() & 8'h0f, 8'h0e);
		din = 4'h0;
		spi_out = 4'h5;
		tick(3);
		chk({4'h0, out_on}, 8'h05);
		vcc_uv = 1'b1;
		tick(3);
		chk({1'b0, out_on, mode}, {1'b0, 4'h0, domc_pkg::MODE_NORMAL});
		vcc_uv = 1'b0;
		tick(3);
		chk({4'h0, out_on}, 8'h05);
		tick(30);
		chk({5'h00, mode}, {5'h00, domc_pkg::MODE_NORMAL});
		mcu.dog_on = 1'b0;
		wm(domc_pkg::MODE_FAIL_SAFE);
		chk(st4() & 8'h0f, 8'h0c);
		$display("test normal done");
	endtask : t_normal
	task automatic t_standby();
		din = 4'h1;
		mcu.write(4'h8);
		mcu.write(4'h4);
		wm(domc_pkg::MODE_STANDBY);
		chk({out_on[0], stat}, 8'h01);
		mcu.write(4'h8);
		mcu.write(4'h2);
		tick(4);
		chk({5'h00, mode}, {5'h00, domc_pkg::MODE_STANDBY});
		din = 4'h0;
		wm(domc_pkg::MODE_SLEEP2);
		din = 4'h8;
		wm(domc_pkg::MODE_STANDBY);
		din = 4'h0;
		wm(domc_pkg::MODE_SLEEP2);
		mcu.cs_hold(6);
		tick(4);
		chk({5'h00, mode}, {5'h00, domc_pkg::MODE_SLEEP2});
		mcu.cs_hold(12);
		wm(domc_pkg::MODE_FAIL_SAFE);
		$display("test standby done");
	endtask : t_standby
	task automatic t_soft();
		mcu.dog_on = 1'b1;
		mcu.write(4'h8);
		mcu.write(4'h2);
		wm(domc_pkg::MODE_NORMAL);
		mcu.write(4'h1);
		wm(domc_pkg::MODE_FAIL_SAFE);
		chk(st4(), 8'h1d);
		mcu.write(4'h8);
		mcu.write(4'h2);
		wm(domc_pkg::MODE_NORMAL);
		mcu.write(4'h0);
		wm(domc_pkg::MODE_FAIL_SAFE);
		vdd_ok = 1'b0;
		wm(domc_pkg::MODE_RESET);
		chk({7'h00, stat.regs_clear}, 8'h01);
		$display("test soft reset done");
	endtask : t_soft
	task automatic t_case();
		hot = 1'b1;
		tick(3);
		chk({7'h00, warn}, 8'h01);
		hot = 1'b0;
		tick(3);
		chk({7'h00, warn}, 8'h01);
		cool = 1'b1;
		tick(3);
		chk({7'h00, warn}, 8'h00);
		$display("test case warning done");
	endtask : t_case
	task automatic t_freeze();
		wm(domc_pkg::MODE_SLEEP1);
		ce = 1'b0;
		vdd_ok = 1'b1;
		tick(4);
		chk({5'h00, mode}, {5'h00, domc_pkg::MODE_SLEEP1});
		ce = 1'b1;
		wm(domc_pkg::MODE_FAIL_SAFE);
		$display("test clock enable done");
	endtask : t_freeze
	initial begin
		tick(8);
		i_rst_n = 1'b1;
		tick(3);
		t_limp();
		t_normal();
		t_standby();
		t_soft();
		t_case();
		t_freeze();
		summarize();
	end
	// Hang guard, well past the few hundred cycles the tests need
	initial begin
		tick(3000);
		miscompares++;
		summarize();
	end
endmodule : testbench
